// ===== bench/fcdma_mem_model.sv
// Purpose: sram and peripheral bus model facing the dma engine
// Assumes: one beat at a time, request held until acknowledged
// Notes:   stalls of 0 to 3 cycles come from a small shift register
module fcdma_mem_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire fcdma_pkg::fcdma_mreq_t  mem_o,
  output logic                         mem_ack,
  output logic [fcdma_pkg::DW-1:0]     mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import fcdma_pkg::*;
  logic [7:0] lfsr_ff;  // stall pattern
  logic [1:0] wait_ff;  // cycles left before the ack
  // reload between beats, so quick and slow answers both occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_ff <= 8'h5b;
      wait_ff <= 2'h0;
    end else begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      if (!mem_o.req || mem_ack) wait_ff <= lfsr_ff[1:0];
      else if (wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
    end
  end
  // each beat serves one direction at the address it carries
  assign mem_ack = mem_o.req && (wait_ff == 2'h0);
  // data inverted outside the ack cycle, so stale data never matches
  assign mem_rdata = mem_ack ? (mem_o.addr ^ 16'ha5c3) : ~(mem_o.addr ^ 16'ha5c3);
endmodule : fcdma_mem_model

// ===== bench/test_four_channel_dma_controller.sv
// Purpose: self-checking bench of the four channel dma engine
// Assumes: bus model answers every beat after a random stall
// Notes:   expected beats are worked out per element from the setup
module test_four_channel_dma_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import fcdma_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, mem_ack, re;
  logic [7:0]   paddr = 8'h0;
  logic [31:0]  pwdata = 32'h0, prdata, rv, seed = 32'h09303769;
  logic [127:0] req_events = '0;
  logic [15:0]  pia_addr = 16'h0, mem_rdata;
  logic [3:0]   dma_irq;
  fcdma_mreq_t  mem_o;
  logic [33:0]  beats[$];  // size, we, addr, wdata of accepted beats
  int errors = 0, samples_checked = 0, irqs[4] = '{0, 0, 0, 0};
  // code, direction, expected default peripheral address
  logic [24:0]  tb[8] = '{{RQ_CAP2, 1'b0, PA_CAP2}, {RQ_CMP3, 1'b1, PA_CMP3},
    {RQ_TMR5, 1'b0, NO_PAD}, {RQ_SER2, 1'b1, PA_SER2}, {RQ_U2RX, 1'b0, PA_U2RX},
    {RQ_CNTX, 1'b1, PA_CNTX}, {RQ_CNRX, 1'b0, PA_CNRX}, {RQ_ADC, 1'b0, PA_ADC}};
  always #50 pclk = ~pclk;
  fcdma_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .req_events, .pia_addr, .mem_o, .mem_ack, .mem_rdata, .dma_irq);
  fcdma_mem_model i_mem (.pclk, .presetn, .mem_o, .mem_ack, .mem_rdata);
  // monitor: log accepted beats, count interrupt pulses
  always @(posedge pclk) begin
    if (mem_o.req && mem_ack) beats.push_back({mem_o.byte_m, mem_o.we, mem_o.addr, mem_o.wdata});
    for (int c = 0; c < 4; c++) if (dma_irq[c] === 1'b1) irqs[c]++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin errors++; end_of_test(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_beats(input int n);
    for (int k = 0; k < 300 && beats.size() < n; k++) @(posedge pclk);
    if (beats.size() < n) begin errors++; end_of_test(); end
  endtask : wait_beats
  // disable first, so enabling re-arms the pointer
  task automatic cfg(input int ch, input logic [7:0] ctl, code, input logic [15:0] sta, stb,
                     input int n);
    logic [7:0] b;
    b = 8'(ch * 32);
    apb(1, b, 0, rv, re);
    apb(1, b + 8'h8, {16'h0, sta}, rv, re);
    apb(1, b + 8'hc, {16'h0, stb}, rv, re);
    apb(1, b + 8'h14, 32'(n - 1), rv, re);
    apb(1, b, {24'h0, ctl}, rv, re);
    apb(1, b + 8'h4, {24'h0, code}, rv, re);
  endtask : cfg
  // run one or two blocks of n elements and compare every beat and interrupt
  task automatic xfer(input int ch, input logic [7:0] ctl, code, input logic [15:0] pad,
                      input int n, input bit ev);
    logic [15:0] sta, stb, ram, src, dst, dv;
    logic [33:0] b;
    int ex;
    sta = 16'(rnd()) & 16'h0ffe;
    stb = sta ^ 16'h4000;
    pia_addr <= 16'(rnd()) & 16'hfffe;
    ex = irqs[ch];
    beats.delete();
    cfg(ch, ctl, code, sta, stb, n);
    for (int k = 0; k < ((ctl[7:6] == MD_ONE) ? n : 2 * n); k++) begin
      if (ev) begin
        @(posedge pclk) req_events[code] <= 1'b1;
        @(posedge pclk) req_events[code] <= 1'b0;
      end else apb(1, 8'(ch * 32 + 4), {16'h0, 8'h80, code}, rv, re);
      wait_beats(2);
      ram = ((k >= n && ctl[7]) ? stb : sta) + 16'(k % n) * ((ctl[5:4] != AM_INC) ? 16'h0 :
            ctl[1] ? STEP_B : STEP_W);
      if (ctl[5:4] == AM_PIA) ram = pia_addr;
      src = ctl[2] ? ram : pad;
      dst = ctl[2] ? pad : ram;
      dv = src ^ 16'ha5c3;
      if (ctl[1]) dv[15:8] = 8'h0;
      b = beats.pop_front();
      chk("read beat", {1'b0, src}, b[32:16]);
      b = beats.pop_front();
      chk("write beat", {ctl[1], 1'b1, dst, dv}, b);
      repeat (4) @(posedge pclk);
      if (ctl[3] ? (k % n + 1 == n / 2) : (k % n == n - 1)) ex++;
      chk("irq count", 33'(ex), 33'(irqs[ch]));
    end
    apb(1, 8'(ch * 32), 0, rv, re);
  endtask : xfer
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STAT, 0, rv, re);
    chk("status at reset", 33'h0, {re, rv});
    apb(0, 8'h84, 0, rv, re);
    chk("unmapped read", {1'b1, 32'h0}, {re, rv});
    // default peripheral address follows code and direction
    for (int t = 0; t < 8; t++) begin
      apb(1, 8'h60, {29'h0, tb[t][16], 2'h0}, rv, re);
      apb(1, 8'h64, {24'h0, tb[t][24:17]}, rv, re);
      apb(0, 8'h70, 0, rv, re);
      chk("default pad", {17'h0, tb[t][15:0]}, {re, rv});
    end
    xfer(0, 8'h01, RQ_U1RX, PA_U1RX, 3, 0);
    xfer(2, 8'h17, RQ_U1TX, PA_U1TX, 2, 0);
    xfer(1, 8'h49, RQ_EXT0, NO_PAD, 4, 1);
    xfer(3, 8'h81, RQ_ADC, PA_ADC, 2, 1);
    xfer(0, 8'h21, RQ_CAP1, PA_CAP1, 1, 0);
    xfer(2, 8'hc3, RQ_SER1, PA_SER1, 2, 1);
    // two channels on one timer event: lower number goes first
    cfg(1, 8'h01, RQ_TMR2, 16'h0200, 16'h0, 1);
    cfg(0, 8'h01, RQ_TMR2, 16'h0100, 16'h0, 1);
    beats.delete();
    @(posedge pclk) req_events[RQ_TMR2] <= 1'b1;
    @(posedge pclk) req_events[RQ_TMR2] <= 1'b0;
    wait_beats(4);
    chk("first grant", {16'h0, 17'h10100}, {16'h0, beats[1][32:16]});
    chk("second grant", {16'h0, 17'h10200}, {16'h0, beats[3][32:16]});
    end_of_test();
  end
endmodule : test_four_channel_dma_controller

// ===== verilog/fcdma_arb.sv
// Purpose: fixed priority pick among channel requests
// Assumes: combinational, sampled by the engine in its idle state
// Notes:   channel 0 ranks highest
module fcdma_arb
  import fcdma_pkg::*;
(
  input  wire logic [NCH-1:0] req,
  output logic      [NCH-1:0] gnt,
  output logic                any,
  output logic      [1:0]     idx
);
  // scan downward so the lowest index written last wins
  always_comb begin
    gnt = '0;
    idx = 2'h0;
    any = |req;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        gnt = '0;
        gnt[i] = 1'b1;
        idx = i[1:0];
      end
    end
  end
endmodule : fcdma_arb

// ===== verilog/fcdma_pkg.sv
// Purpose: shared constants and types of the four channel dma controller
// Assumes: 16-bit data space, apb register window of 256 bytes
// Notes:   request codes above 8'h7f never fire in this build
package fcdma_pkg;
  localparam int NCH = 4;                    // channel count
  localparam int AW  = 16;                   // data space address width
  localparam int DW  = 16;                   // data width
  // word index inside a channel window (byte offset = 4 * index)
  localparam logic [2:0] RI_CTRL = 3'h0;
  localparam logic [2:0] RI_SEL  = 3'h1;
  localparam logic [2:0] RI_STA  = 3'h2;
  localparam logic [2:0] RI_STB  = 3'h3;
  localparam logic [2:0] RI_PAD  = 3'h4;
  localparam logic [2:0] RI_CNT  = 3'h5;
  localparam logic [2:0] RI_XFER = 3'h6;
  localparam logic [2:0] RI_STAT = 3'h7;
  localparam logic [7:0] OFF_STAT = 8'h80;   // global status word
  // control word fields
  localparam int CB_EN   = 0;
  localparam int CB_BYTE = 1;
  localparam int CB_DIR  = 2;                // 1: sram to peripheral
  localparam int CB_HALF = 3;
  localparam int CB_AM   = 4;                // 2 bits
  localparam int CB_MD   = 6;                // 2 bits
  localparam int SB_TRIG = 15;               // manual trigger in select word
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_FIX = 2'h1;
  localparam logic [1:0] AM_PIA = 2'h2;
  localparam logic [1:0] MD_ONE = 2'h0;
  localparam logic [1:0] MD_RPT = 2'h1;
  localparam logic [1:0] MD_PP1 = 2'h2;      // ping-pong, stop after 2nd block
  localparam logic [1:0] MD_PPR = 2'h3;      // ping-pong, repeat
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [15:0] NO_PAD  = 16'h0000;
  localparam logic [15:0] STEP_B  = 16'h0001;
  localparam logic [15:0] STEP_W  = 16'h0002;
  // request source codes
  localparam logic [7:0] RQ_EXT0 = 8'h00;
  localparam logic [7:0] RQ_CAP1 = 8'h01;
  localparam logic [7:0] RQ_CAP2 = 8'h05;
  localparam logic [7:0] RQ_CAP3 = 8'h25;
  localparam logic [7:0] RQ_CAP4 = 8'h26;
  localparam logic [7:0] RQ_CMP1 = 8'h02;
  localparam logic [7:0] RQ_CMP2 = 8'h06;
  localparam logic [7:0] RQ_CMP3 = 8'h19;
  localparam logic [7:0] RQ_CMP4 = 8'h1a;
  localparam logic [7:0] RQ_TMR2 = 8'h07;
  localparam logic [7:0] RQ_TMR3 = 8'h08;
  localparam logic [7:0] RQ_TMR4 = 8'h1b;
  localparam logic [7:0] RQ_TMR5 = 8'h1c;
  localparam logic [7:0] RQ_SER1 = 8'h0a;
  localparam logic [7:0] RQ_SER2 = 8'h21;
  localparam logic [7:0] RQ_U1RX = 8'h0b;
  localparam logic [7:0] RQ_U1TX = 8'h0c;
  localparam logic [7:0] RQ_U2RX = 8'h1e;
  localparam logic [7:0] RQ_U2TX = 8'h1f;
  localparam logic [7:0] RQ_CNRX = 8'h22;
  localparam logic [7:0] RQ_CNTX = 8'h46;
  localparam logic [7:0] RQ_ADC  = 8'h0d;
  // peripheral data addresses; second compare word is for software use
  localparam logic [15:0] PA_CAP1 = 16'h0144;
  localparam logic [15:0] PA_CAP2 = 16'h014c;
  localparam logic [15:0] PA_CAP3 = 16'h0154;
  localparam logic [15:0] PA_CAP4 = 16'h015c;
  localparam logic [15:0] PA_CMP1 = 16'h0906;
  localparam logic [15:0] PA_CMP1S = 16'h0904;
  localparam logic [15:0] PA_CMP2 = 16'h0910;
  localparam logic [15:0] PA_CMP2S = 16'h090e;
  localparam logic [15:0] PA_CMP3 = 16'h091a;
  localparam logic [15:0] PA_CMP3S = 16'h0918;
  localparam logic [15:0] PA_CMP4 = 16'h0924;
  localparam logic [15:0] PA_CMP4S = 16'h0922;
  localparam logic [15:0] PA_SER1 = 16'h0248;
  localparam logic [15:0] PA_SER2 = 16'h0268;
  localparam logic [15:0] PA_U1RX = 16'h0226;
  localparam logic [15:0] PA_U1TX = 16'h0224;
  localparam logic [15:0] PA_U2RX = 16'h0236;
  localparam logic [15:0] PA_U2TX = 16'h0234;
  localparam logic [15:0] PA_CNRX = 16'h0440;
  localparam logic [15:0] PA_CNTX = 16'h0442;
  localparam logic [15:0] PA_ADC  = 16'h0300;
  // data bus request toward sram and peripherals
  typedef struct packed {
    logic          req;
    logic          we;
    logic          byte_m;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } fcdma_mreq_t;
  // default peripheral address for a source code and direction
  function automatic logic [AW-1:0] fcdma_pad_dflt(input logic [7:0] code, input logic wr);
    logic [AW-1:0] r;
    r = NO_PAD;
    case (code)
      RQ_EXT0, RQ_TMR2, RQ_TMR3, RQ_TMR4, RQ_TMR5: r = NO_PAD;
      RQ_CAP1: r = wr ? NO_PAD : PA_CAP1;
      RQ_CAP2: r = wr ? NO_PAD : PA_CAP2;
      RQ_CAP3: r = wr ? NO_PAD : PA_CAP3;
      RQ_CAP4: r = wr ? NO_PAD : PA_CAP4;
      RQ_CMP1: r = wr ? PA_CMP1 : NO_PAD;
      RQ_CMP2: r = wr ? PA_CMP2 : NO_PAD;
      RQ_CMP3: r = wr ? PA_CMP3 : NO_PAD;
      RQ_CMP4: r = wr ? PA_CMP4 : NO_PAD;
      RQ_SER1: r = PA_SER1;
      RQ_SER2: r = PA_SER2;
      RQ_U1RX: r = wr ? NO_PAD : PA_U1RX;
      RQ_U1TX: r = wr ? PA_U1TX : NO_PAD;
      RQ_U2RX: r = wr ? NO_PAD : PA_U2RX;
      RQ_U2TX: r = wr ? PA_U2TX : NO_PAD;
      RQ_CNRX: r = wr ? NO_PAD : PA_CNRX;
      RQ_CNTX: r = wr ? PA_CNTX : NO_PAD;
      RQ_ADC:  r = wr ? NO_PAD : PA_ADC;
      default: r = NO_PAD;
    endcase
    return r;
  endfunction : fcdma_pad_dflt
endpackage : fcdma_pkg

// ===== verilog/fcdma_top.sv
// Purpose: four channel dma engine with apb register window
// Assumes: data bus answers with mem_ack; events and pia_addr share pclk
// Notes:   one element moves per granted request
// Function
// - timer and external events can request transfers
// - each channel moves one direction only
// - fixed rank picks one, others stay pending
// - interrupt after whole block completes
// - interrupt at half block or full block
// - indirect mode with sram post-increment
// - indirect mode with fixed sram address
// - peripheral supplies address in peripheral-indirect mode
// - byte or word per transfer
// - start by software trigger or peripheral request
// - one-shot stops, auto-repeat restarts block
// - ping-pong swaps start address each block
// - 8-bit code selects request source
// - external int and timer codes, no address
// - capture codes read capture buffers
// - compare codes write compare registers
// - serial port codes read and write buffers
// - uart receive and transmit codes and buffers
// - can receive and transmit codes and addresses
// - converter done code reads first buffer
module fcdma_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [127:0]              req_events,
  input  wire logic [fcdma_pkg::AW-1:0]  pia_addr,
  output fcdma_pkg::fcdma_mreq_t         mem_o,
  input  wire logic                      mem_ack,
  input  wire logic [fcdma_pkg::DW-1:0]  mem_rdata,
  output logic      [fcdma_pkg::NCH-1:0] dma_irq
);
  import fcdma_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_RD, S_WR, S_FIN} fcdma_st_t;

  // software registers, one word each per channel
  logic [DW-1:0]  ctrl_ff [NCH];   // control word
  logic [7:0]     sel_ff  [NCH];   // request source code
  logic [AW-1:0]  sta_ff  [NCH];   // start address a
  logic [AW-1:0]  stb_ff  [NCH];   // start address b
  logic [AW-1:0]  pad_ff  [NCH];   // peripheral address
  logic [DW-1:0]  cnt_ff  [NCH];   // elements per block minus one
  // channel progress
  logic [AW-1:0]  ptr_ff  [NCH];   // current sram address
  logic [DW-1:0]  xfer_ff [NCH];   // elements done in block
  logic [NCH-1:0] pp_ff;           // ping-pong half in use
  logic [NCH-1:0] pend_ff;         // latched requests
  logic [NCH-1:0] irq_ff;          // interrupt pulses
  // engine
  fcdma_st_t      st_ff;
  logic [1:0]     ch_ff;           // active channel
  logic [AW-1:0]  pia_ff;          // address from peripheral
  fcdma_mreq_t    mem_ff;          // bus request
  // apb answer
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;

  // decoded access
  logic           d_hit;
  logic [1:0]     d_ch;
  logic [2:0]     d_idx;
  logic           wr_go;
  logic [31:0]    rd_word;
  logic [AW-1:0]  pad_new;
  // per channel strobes
  logic [NCH-1:0] en_v;
  logic [NCH-1:0] ev_v;
  logic [NCH-1:0] trig_v;
  logic [NCH-1:0] arm_v;
  logic [NCH-1:0] stop_v;
  logic [NCH-1:0] rdy_v;
  logic [NCH-1:0] gnt;
  logic           g_any;
  logic [1:0]     g_idx;
  // active channel view
  logic [DW-1:0]  c_ctl;
  logic           c_byte;
  logic           c_dir;
  logic           c_half;
  logic [1:0]     c_am;
  logic [1:0]     c_md;
  logic [AW-1:0]  cur_ptr;
  logic [AW-1:0]  ram_a;
  logic [AW-1:0]  src_a;
  logic [AW-1:0]  dst_a;
  logic [AW-1:0]  step;
  logic [16:0]    xfer_n;
  logic [16:0]    total;
  logic           last;
  logic           at_half;

  // address decode: {hit, channel, word index}
  function automatic logic [5:0] fcdma_dec(input logic [7:0] a);
    logic [5:0] r;
    r = 6'h00;
    if (a == OFF_STAT) begin
      r = {1'b1, 2'h0, RI_STAT};
    end else if (!a[7] && a[1:0] == 2'h0 && a[4:2] != RI_STAT) begin
      r = {1'b1, a[6:5], a[4:2]};
    end
    return r;
  endfunction : fcdma_dec

  assign {d_hit, d_ch, d_idx} = fcdma_dec(paddr);
  // writes land only on the completing edge
  assign wr_go   = psel & penable & pready_ff & pwrite & d_hit;
  assign pad_new = fcdma_pad_dflt(pwdata[7:0], ctrl_ff[d_ch][CB_DIR]);

  // per channel request terms
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic sel_w;
      assign sel_w      = wr_go && d_ch == gi && d_idx == RI_SEL;
      assign en_v[gi]   = ctrl_ff[gi][CB_EN];
      // codes with bit 7 set have no event line
      assign ev_v[gi]   = !sel_ff[gi][7] && req_events[sel_ff[gi][6:0]];
      assign trig_v[gi] = sel_w && pwdata[SB_TRIG];
      // enabling from off restarts the block
      assign arm_v[gi]  = wr_go && d_ch == gi && d_idx == RI_CTRL
                          && pwdata[CB_EN] && !ctrl_ff[gi][CB_EN];
      assign stop_v[gi] = st_ff == S_FIN && ch_ff == gi && last
                          && (c_md == MD_ONE || (c_md == MD_PP1 && pp_ff[gi]));
    end
  endgenerate

  assign rdy_v = pend_ff & en_v;

  fcdma_arb u_arb (
    .req (rdy_v),
    .gnt (gnt),
    .any (g_any),
    .idx (g_idx)
  );

  // active channel fields
  assign c_ctl   = ctrl_ff[ch_ff];
  assign c_byte  = c_ctl[CB_BYTE];
  assign c_dir   = c_ctl[CB_DIR];
  assign c_half  = c_ctl[CB_HALF];
  assign c_am    = c_ctl[CB_AM +: 2];
  assign c_md    = c_ctl[CB_MD +: 2];
  assign cur_ptr = ptr_ff[ch_ff];
  // peripheral-indirect takes the address the peripheral handed over
  assign ram_a   = (c_am == AM_PIA) ? pia_ff : cur_ptr;
  // one fixed direction per channel
  assign src_a   = c_dir ? ram_a : pad_ff[ch_ff];
  assign dst_a   = c_dir ? pad_ff[ch_ff] : ram_a;
  assign step    = c_byte ? STEP_B : STEP_W;
  assign xfer_n  = {1'b0, xfer_ff[ch_ff]} + 17'h00001;
  assign total   = {1'b0, cnt_ff[ch_ff]} + 17'h00001;
  assign last    = xfer_n == total;
  assign at_half = xfer_n == (total >> 1);

  // software registers; a write beats the engine's enable clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_ff[i] <= RST_REG;
        sel_ff[i]  <= RST_REG[7:0];
        sta_ff[i]  <= RST_REG;
        stb_ff[i]  <= RST_REG;
        pad_ff[i]  <= RST_REG;
        cnt_ff[i]  <= RST_REG;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_go && d_ch == i) begin
          case (d_idx)
            RI_CTRL: ctrl_ff[i] <= pwdata[15:0];
            RI_SEL: begin
              sel_ff[i] <= pwdata[7:0];
              pad_ff[i] <= pad_new;        // preload known peripheral address
            end
            RI_STA:  sta_ff[i] <= pwdata[15:0];
            RI_STB:  stb_ff[i] <= pwdata[15:0];
            RI_PAD:  pad_ff[i] <= pwdata[15:0];
            RI_CNT:  cnt_ff[i] <= pwdata[15:0];
            default: ;                     // progress word is read only
          endcase
        end else if (stop_v[i]) begin
          ctrl_ff[i][CB_EN] <= 1'b0;
        end
      end
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (d_idx)
      RI_CTRL: rd_word[15:0] = ctrl_ff[d_ch];
      RI_SEL:  rd_word[7:0]  = sel_ff[d_ch];
      RI_STA:  rd_word[15:0] = sta_ff[d_ch];
      RI_STB:  rd_word[15:0] = stb_ff[d_ch];
      RI_PAD:  rd_word[15:0] = pad_ff[d_ch];
      RI_CNT:  rd_word[15:0] = cnt_ff[d_ch];
      RI_XFER: rd_word[15:0] = xfer_ff[d_ch];
      RI_STAT: rd_word[15:0] = {pp_ff, pend_ff, en_v, 1'b0, st_ff != S_IDLE, ch_ff};
      default: rd_word = 32'h0000_0000;
    endcase
    if (!d_hit) begin
      rd_word = 32'h0000_0000;
    end
  end

  // apb: one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !d_hit;
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // pending requests; a new request in the grant cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~((st_ff == S_IDLE) ? gnt : '0))
                 | (en_v & (ev_v | trig_v));
    end
  end

  // engine: grant, read element, write element, account
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff  <= S_IDLE;
      ch_ff  <= 2'h0;
      pia_ff <= '0;
      mem_ff <= '0;
    end else begin
      case (st_ff)
        S_IDLE: begin
          if (g_any) begin
            ch_ff  <= g_idx;
            pia_ff <= pia_addr;
            st_ff  <= S_LOAD;
          end
        end
        S_LOAD: begin
          mem_ff.req    <= 1'b1;
          mem_ff.we     <= 1'b0;
          mem_ff.byte_m <= c_byte;
          mem_ff.addr   <= src_a;
          mem_ff.wdata  <= '0;
          st_ff         <= S_RD;
        end
        S_RD: begin
          if (mem_ack) begin
            mem_ff.we    <= 1'b1;
            mem_ff.addr  <= dst_a;
            // byte moves keep the upper lane clear
            mem_ff.wdata <= c_byte ? {8'h00, mem_rdata[7:0]} : mem_rdata;
            st_ff        <= S_WR;
          end
        end
        S_WR: begin
          if (mem_ack) begin
            mem_ff.req <= 1'b0;
            mem_ff.we  <= 1'b0;
            st_ff      <= S_FIN;
          end
        end
        S_FIN:   st_ff <= S_IDLE;
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // address and count progress per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        ptr_ff[i]  <= RST_REG;
        xfer_ff[i] <= RST_REG;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (arm_v[i]) begin
          ptr_ff[i]  <= sta_ff[i];
          xfer_ff[i] <= RST_REG;
          pp_ff[i]   <= 1'b0;
        end else if (st_ff == S_FIN && ch_ff == i) begin
          if (last) begin
            xfer_ff[i] <= RST_REG;
            if (c_md[1]) begin
              pp_ff[i]  <= !pp_ff[i];
              ptr_ff[i] <= pp_ff[i] ? sta_ff[i] : stb_ff[i];
            end else begin
              ptr_ff[i] <= sta_ff[i];
            end
          end else begin
            xfer_ff[i] <= xfer_n[15:0];
            if (c_am == AM_INC) begin
              ptr_ff[i] <= ptr_ff[i] + step;
            end                              // fixed mode holds
          end
        end
      end
    end
  end

  // block or half block interrupt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        irq_ff[i] <= st_ff == S_FIN && ch_ff == i && (c_half ? at_half : last);
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign mem_o   = mem_ff;
  assign dma_irq = irq_ff;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_event_pend: assert property ((en_v[0] && ev_v[0]) |=> pend_ff[0])
    else $error("event lost on channel 0");
  a_grant_top: assert property ((st_ff == S_IDLE && rdy_v[0]) |=> ch_ff == 2'h0)
    else $error("channel 0 not granted first");
  a_pend_kept: assert property ((st_ff == S_IDLE && rdy_v[1:0] == 2'h3) |=> pend_ff[1])
    else $error("lower request dropped");
  a_low_rank: assert property ((st_ff == S_IDLE && rdy_v == 4'h8) |=> ch_ff == 2'h3)
    else $error("lone channel 3 not served");
  a_dir_dest: assert property ((st_ff == S_RD && mem_ack)
    |=> mem_ff.we && mem_ff.addr == $past(dst_a))
    else $error("write went to wrong side");
  a_blk_irq: assert property ((st_ff == S_FIN && last && !c_half)
    |=> irq_ff[$past(ch_ff)])
    else $error("no block interrupt");
  a_half_irq: assert property ((st_ff == S_FIN && at_half && c_half)
    |=> irq_ff[$past(ch_ff)])
    else $error("no half block interrupt");
  a_addr_inc: assert property ((st_ff == S_FIN && !last && c_am == AM_INC && !arm_v[ch_ff])
    |=> cur_ptr == $past(cur_ptr) + $past(step))
    else $error("sram address not advanced");
  a_addr_fix: assert property ((st_ff == S_FIN && !last && c_am == AM_FIX && !arm_v[ch_ff])
    |=> cur_ptr == $past(cur_ptr))
    else $error("fixed address moved");
  // sram side is the outgoing read address, or the write address on the way back
  a_pia_src: assert property ((c_am == AM_PIA && (c_dir ? st_ff == S_LOAD :
    st_ff == S_RD && mem_ack)) |=> mem_ff.addr == pia_ff)
    else $error("peripheral address not used");
  a_size_sel: assert property ((st_ff == S_LOAD) |=> mem_ff.req && mem_ff.byte_m == $past(c_byte))
    else $error("transfer size mismatch");
  a_manual_go: assert property ((trig_v[0] && en_v[0]) |=> pend_ff[0] ##1 st_ff != S_IDLE)
    else $error("manual trigger ignored");
  a_one_shot: assert property ((st_ff == S_FIN && last && c_md == MD_ONE && !wr_go)
    |=> !en_v[$past(ch_ff)])
    else $error("one-shot did not stop");
  a_pp_swap: assert property ((st_ff == S_FIN && last && c_md[1] && !arm_v[ch_ff])
    |=> pp_ff[$past(ch_ff)] != $past(pp_ff[ch_ff]))
    else $error("ping-pong did not swap");
  a_pad_load: assert property ((wr_go && d_idx == RI_SEL) |=> pad_ff[$past(d_ch)] == $past(pad_new))
    else $error("peripheral address not preloaded");

  c_pp_swap: cover property (st_ff == S_FIN && last && c_md == MD_PPR);
  c_half_hit: cover property (st_ff == S_FIN && at_half && c_half);
  c_contend: cover property (st_ff == S_IDLE && rdy_v == 4'hf);
  c_manual: cover property (trig_v[2] && en_v[2]);
endmodule : fcdma_top
